// File: src/pmc_map.vh
// Constants for the processor power mode controller
`ifndef PMC_MAP_VH
`define PMC_MAP_VH
`define PMC_HALT_OPCODE 8'h76
`define PMC_SLEEP_OP0 8'hed
`define PMC_SLEEP_OP1 8'h76
`define PMC_RESET_MIN_CYC 3'h6
`define PMC_IO_STOP_BIT_RST 1'b0
`define PMC_ADDR_IDLE 20'hfffff
`define PMC_ADDR_ZERO 20'h00000
`define PMC_SRC_NMI 0
`define PMC_SRC_EXTERNAL_INTERRUPT_LINE_ZERO 1
`define PMC_SRC_EXTERNAL_INTERRUPT_LINE_ONE 2
`define PMC_SRC_EXTERNAL_INTERRUPT_LINE_TWO 3
`define PMC_SRC_SER0 4
`define PMC_SRC_SER1 5
`define PMC_SRC_CSIO 6
`define PMC_SRC_TMR0 7
`define PMC_SRC_TMR1 8
`define PMC_NSRC 9
`define PMC_IO_SRC_MASK 9'h1f0
`endif

// File: src/pmc_reset_filter.v
// Reset pin filter: pulse once the pin has stayed low long enough
`timescale 1ns/1ps
`include "pmc_map.vh"
module pmc_reset_filter (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Reset pin level and result
    input wire reset_pin_n,
    output reg reset_hit_reg
);
    reg [2:0] low_cnt_reg;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_reg <= 3'h0;
            reset_hit_reg <= 1'b0;
        end else if (reset_pin_n) begin
            low_cnt_reg <= 3'h0;
            reset_hit_reg <= 1'b0;
        end else begin
            if (low_cnt_reg != `PMC_RESET_MIN_CYC)
                low_cnt_reg <= low_cnt_reg + 3'h1;
            reset_hit_reg <= (low_cnt_reg == (`PMC_RESET_MIN_CYC - 3'h1));
        end
    end
endmodule // pmc_reset_filter

// File: src/pmc_power_ctrl.v
// Halt, sleep, I/O stop and system stop mode controller
// Operation
// - Halt opcode enters halt; clock runs, execution stops, dummy fetches repeat.
// - In halt, interrupts, bus exchange, refresh, serial, timer and DMA continue.
// - Halt indication output is low throughout halt mode.
// - Reset low six cycles leaves halt and restarts at address zero.
// - Unmasked interrupt ends halt; masked stays halted; NMI always responds.
// - Two-byte sleep instruction enters sleep; CPU clock stops, oscillator runs.
// - Sleep stops refresh and DMA; peripherals and interrupt inputs continue.
// - Bus requests are still accepted and granted while asleep.
// - Asleep, addresses and controls drive high; data bus released.
// - Reset low six cycles ends sleep and restarts at address zero.
// - Only NMI, three external lines, serial, CSI and timers wake sleep.
// - NMI during sleep wakes and starts NMI response.
// - Individually disabled interrupt is ignored during sleep.
// - Enabled interrupt with global enable set wakes and takes response.
// - Enabled interrupt with global enable clear wakes, resumes after sleep.
// - Request during sleep fetch gives halt indication low one state.
// - I/O stop bit stops serial, CSI and timers; clearing resumes them.
// - I/O stop plus sleep stops both; stopped I/O cannot wake.
// - I/O stop bit clears to zero at reset.
`timescale 1ns/1ps
`include "pmc_map.vh"
module pmc_power_ctrl (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    // Reset pin, held low from outside
    input wire reset_pin_n,
    // Opcode stream from the core
    input wire opcode_valid,
    input wire [7:0] opcode,
    input wire [19:0] pc_next_addr,
    // I/O stop bit write
    input wire io_stop_wr,
    input wire io_stop_wdata,
    // Interrupt requests, enables, global flag
    input wire [8:0] irq_req,
    input wire [8:0] irq_enable,
    input wire global_interrupt_enable_flag,
    // External bus request
    input wire bus_request_input_n,
    // Core bus cycle outputs
    input wire [19:0] core_addr,
    input wire core_mreq_n,
    input wire core_ioreq_n,
    input wire core_rd_n,
    input wire core_wr_n,
    input wire [7:0] core_data_out,
    input wire core_data_oe,
    // Bus pins
    output reg [19:0] addr_out_reg,
    output reg mem_en_n_reg,
    output reg io_en_n_reg,
    output reg rd_n_reg,
    output reg wr_n_reg,
    output reg [7:0] data_o_reg,
    output reg data_oe_n_reg,
    output reg bus_grant_output_n_reg,
    // Mode indications and clock gates
    output reg halt_n_reg,
    output wire cpu_clk_en,
    output wire exec_en,
    output wire refresh_en,
    output wire dma_controller_en,
    output wire async_serial_channel_en,
    output wire csio_en,
    output wire reload_timer_en,
    output reg io_stop_bit_reg,
    // Wake and restart requests to the core
    output reg irq_response_reg,
    output reg [3:0] irq_source_reg,
    output reg resume_after_sleep_reg,
    output reg restart_reg,
    output reg [19:0] restart_addr_reg,
    output reg [19:0] dummy_fetch_addr_reg
);
    localparam ST_RUN = 2'd0;
    localparam ST_HALT = 2'd1;
    localparam ST_SLEEP_ARM = 2'd2;
    localparam ST_SLEEP = 2'd3;

    reg rst_s1_reg;
    reg rst_n_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg prefix_reg;
    wire reset_hit;
    wire [8:0] live_req;
    wire [8:0] eligible;
    wire any_wake;
    reg [3:0] first_src;
    integer i;

    // ************************************************************
    // Reset release
    // ************************************************************
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    pmc_reset_filter u_reset_filter (
        .sys_clk(sys_clk),
        .rst_n(rst_n_reg),
        .reset_pin_n(reset_pin_n),
        .reset_hit_reg(reset_hit)
    );

    // ************************************************************
    // Wake eligibility
    // ************************************************************
    // Stopped on-chip I/O cannot raise a request
    assign live_req = irq_req & ~({`PMC_NSRC{io_stop_bit_reg}} & `PMC_IO_SRC_MASK);
    assign eligible = live_req & (irq_enable | 9'h001);
    assign any_wake = |eligible;

    always @* begin
        first_src = 4'h0;
        for (i = `PMC_NSRC - 1; i >= 0; i = i - 1) begin
            if (eligible[i])
                first_src = i[3:0];
        end
    end

    // ************************************************************
    // Mode state machine
    // ************************************************************
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (opcode_valid && prefix_reg && opcode == `PMC_SLEEP_OP1)
                    state_next = ST_SLEEP_ARM;
                else if (opcode_valid && !prefix_reg && opcode == `PMC_HALT_OPCODE)
                    state_next = ST_HALT;
            end
            ST_HALT: begin
                if (any_wake && (eligible[`PMC_SRC_NMI] || global_interrupt_enable_flag))
                    state_next = ST_RUN;
            end
            ST_SLEEP_ARM: begin
                // A request already pending cuts sleep to one state
                if (any_wake)
                    state_next = ST_RUN;
                else
                    state_next = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (any_wake)
                    state_next = ST_RUN;
            end
            default: state_next = ST_RUN;
        endcase
    end

    always @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ST_RUN;
            prefix_reg <= 1'b0;
            io_stop_bit_reg <= `PMC_IO_STOP_BIT_RST;
            irq_response_reg <= 1'b0;
            irq_source_reg <= 4'h0;
            resume_after_sleep_reg <= 1'b0;
            restart_reg <= 1'b0;
            restart_addr_reg <= `PMC_ADDR_ZERO;
            dummy_fetch_addr_reg <= `PMC_ADDR_ZERO;
            halt_n_reg <= 1'b1;
        end else if (reset_hit) begin
            state_reg <= ST_RUN;
            prefix_reg <= 1'b0;
            io_stop_bit_reg <= `PMC_IO_STOP_BIT_RST;
            irq_response_reg <= 1'b0;
            resume_after_sleep_reg <= 1'b0;
            restart_reg <= 1'b1;
            restart_addr_reg <= `PMC_ADDR_ZERO;
            halt_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            restart_reg <= 1'b0;
            if (opcode_valid && state_reg == ST_RUN)
                prefix_reg <= (opcode == `PMC_SLEEP_OP0) && !prefix_reg;
            if (io_stop_wr)
                io_stop_bit_reg <= io_stop_wdata;
            if (state_reg == ST_RUN && state_next == ST_HALT)
                dummy_fetch_addr_reg <= pc_next_addr;
            halt_n_reg <= (state_next == ST_RUN);
            irq_response_reg <= 1'b0;
            resume_after_sleep_reg <= 1'b0;
            if (state_reg != ST_RUN && state_next == ST_RUN) begin
                irq_source_reg <= first_src;
                if (eligible[`PMC_SRC_NMI] || global_interrupt_enable_flag)
                    irq_response_reg <= 1'b1;
                else
                    resume_after_sleep_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Clock and function enables
    // ************************************************************
    wire asleep = (state_reg == ST_SLEEP) || (state_reg == ST_SLEEP_ARM);
    assign cpu_clk_en = !asleep;
    assign exec_en = (state_reg == ST_RUN);
    assign refresh_en = !asleep;
    assign dma_controller_en = !asleep;
    assign async_serial_channel_en = !io_stop_bit_reg;
    assign csio_en = !io_stop_bit_reg;
    assign reload_timer_en = !io_stop_bit_reg;

    // ************************************************************
    // Bus pins and bus exchange
    // ************************************************************
    always @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            addr_out_reg <= `PMC_ADDR_IDLE;
            mem_en_n_reg <= 1'b1;
            io_en_n_reg <= 1'b1;
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            data_o_reg <= 8'h00;
            data_oe_n_reg <= 1'b1;
            bus_grant_output_n_reg <= 1'b1;
        end else begin
            bus_grant_output_n_reg <= bus_request_input_n;
            if (asleep) begin
                addr_out_reg <= `PMC_ADDR_IDLE;
                mem_en_n_reg <= 1'b1;
                io_en_n_reg <= 1'b1;
                rd_n_reg <= 1'b1;
                wr_n_reg <= 1'b1;
                data_oe_n_reg <= 1'b1;
            end else if (state_reg == ST_HALT) begin
                addr_out_reg <= dummy_fetch_addr_reg;
                mem_en_n_reg <= 1'b0;
                io_en_n_reg <= 1'b1;
                rd_n_reg <= 1'b0;
                wr_n_reg <= 1'b1;
                data_oe_n_reg <= 1'b1;
            end else begin
                addr_out_reg <= core_addr;
                mem_en_n_reg <= core_mreq_n;
                io_en_n_reg <= core_ioreq_n;
                rd_n_reg <= core_rd_n;
                wr_n_reg <= core_wr_n;
                data_o_reg <= core_data_out;
                data_oe_n_reg <= !core_data_oe;
            end
        end
    end
endmodule // pmc_power_ctrl

// File: tb/pmc_power_ctrl_sva.sv
// Port checker for the power mode controller
`timescale 1ns/1ps
`include "pmc_map.vh"
module pmc_power_ctrl_sva (
    // Clock and reset
    input wire sys_clk,
    input wire arst_n,
    // Inputs
    input wire reset_pin_n,
    input wire opcode_valid,
    input wire [7:0] opcode,
    input wire [8:0] irq_req,
    input wire [8:0] irq_enable,
    input wire global_interrupt_enable_flag,
    input wire bus_request_input_n,
    // Outputs
    input wire [19:0] addr_out_reg,
    input wire bus_grant_output_n_reg,
    input wire halt_n_reg,
    input wire cpu_clk_en,
    input wire io_stop_bit_reg,
    input wire irq_response_reg,
    input wire resume_after_sleep_reg,
    input wire restart_reg
);
    // ****************************
    // Sleep wake sources and rules
    // ****************************
    wire [8:0] wake = irq_req & {irq_enable[8:1], 1'h1} & ~({9{io_stop_bit_reg}} & `PMC_IO_SRC_MASK);
    // Pin level one clock back: a restart from the pin also lifts sleep
    reg pin_prev_reg;
    always @(posedge sys_clk) begin
        pin_prev_reg <= reset_pin_n;
    end
    wire asleep = !cpu_clk_en && reset_pin_n && pin_prev_reg;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    AST_HALT_ENTER: assert property (opcode_valid && opcode == `PMC_HALT_OPCODE && halt_n_reg
        && $past(opcode) != `PMC_SLEEP_OP0 |=> !halt_n_reg) else $error("no halt");
    AST_SLEEP_ENTER: assert property ($past(opcode_valid) && $past(opcode) == `PMC_SLEEP_OP0
        && opcode_valid && opcode == `PMC_SLEEP_OP1 && halt_n_reg |=> !cpu_clk_en && !halt_n_reg)
        else $error("no sleep");
    AST_SLEEP_BUS: assert property (asleep && !$past(cpu_clk_en) && bus_grant_output_n_reg
        && $past(bus_grant_output_n_reg) |-> addr_out_reg == `PMC_ADDR_IDLE) else $error("bus");
    AST_NMI_WAKE: assert property (!halt_n_reg && irq_req[`PMC_SRC_NMI] && reset_pin_n && pin_prev_reg
        |=> halt_n_reg && irq_response_reg) else $error("nmi");
    AST_SLEEP_HOLD: assert property (asleep && wake == 9'h000 |=> !cpu_clk_en)
        else $error("woke");
    AST_SLEEP_RESUME: assert property (asleep && wake != 9'h000 && !irq_req[0]
        && !global_interrupt_enable_flag |=> resume_after_sleep_reg && !irq_response_reg)
        else $error("resume");
    AST_RESET_PIN: assert property ($fell(reset_pin_n) ##1 !reset_pin_n [*5]
        |=> ##1 restart_reg && !io_stop_bit_reg) else $error("restart");
    AST_GRANT: assert property (!bus_request_input_n |=> !bus_grant_output_n_reg)
        else $error("grant");
endmodule // pmc_power_ctrl_sva
bind pmc_power_ctrl pmc_power_ctrl_sva chk_u (.*);

// File: tb/pmc_core_model.sv
// Core and external bus master model facing the controller
`timescale 1ns/1ps
module pmc_core_model (
    // Clock and bench command
    input wire sys_clk,
    input wire want_bus,
    // Bus request and core address stream
    output reg bus_request_input_n,
    output reg [19:0] core_addr
);
    initial begin
        bus_request_input_n = 1'h1;
        core_addr = 20'h00000;
    end
    // Request trails the command by one clock; address steps every cycle
    always @(posedge sys_clk) begin
        bus_request_input_n <= !want_bus;
        core_addr <= core_addr + 20'h00001;
    end
endmodule // pmc_core_model

// File: tb/pmc_power_ctrl_bench.sv
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
`include "pmc_map.vh"
module pmc_power_ctrl_bench;
    reg sys_clk, arst_n, reset_pin_n, opcode_valid, io_stop_wr, io_stop_wdata, want_bus;
    reg global_interrupt_enable_flag;
    reg [7:0] opcode;
    reg [8:0] irq_req, irq_enable;
    reg [19:0] pc_next_addr;
    wire core_ioreq_n = 1'h1;
    wire core_wr_n = 1'h1;
    wire core_data_oe = 1'h0;
    wire [19:0] core_addr, addr_out_reg, restart_addr_reg, dummy_fetch_addr_reg;
    wire [7:0] core_data_out = core_addr[7:0];
    wire core_mreq_n = core_addr[0];
    wire core_rd_n = core_addr[0];
    wire [7:0] data_o_reg;
    wire [3:0] irq_source_reg;
    wire bus_request_input_n, mem_en_n_reg, io_en_n_reg, rd_n_reg, wr_n_reg, data_oe_n_reg;
    wire bus_grant_output_n_reg, halt_n_reg, cpu_clk_en, exec_en, refresh_en, dma_controller_en;
    wire async_serial_channel_en, csio_en, reload_timer_en, io_stop_bit_reg, irq_response_reg;
    wire resume_after_sleep_reg, restart_reg;
    integer err_count, total_checks;
    pmc_power_ctrl dut_u (.*);
    pmc_core_model core_u (.*);
    // ******************
    // Driving and checks
    // ******************
    task chk(input [8*8:1] what, input [19:0] seen, input [19:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, seen);
        end
    endtask
    task edges(input integer n);
        repeat (n) @(posedge sys_clk);
    endtask
    task send(input [7:0] b);
        edges(1);
        opcode_valid <= 1'h1;
        opcode <= b;
    endtask
    task wr_io(input v);
        edges(1);
        io_stop_wr <= 1'h1;
        io_stop_wdata <= v;
        edges(1);
        io_stop_wr <= 1'h0;
        #1;
    endtask
    task t_halt;
        send(`PMC_HALT_OPCODE);
        pc_next_addr <= 20'h12345;
        edges(1);
        opcode_valid <= 1'h0;
        irq_req <= 9'h002;
        #1;
        chk("halt_n", halt_n_reg, 1'h0);
        chk("exec", exec_en, 1'h0);
        edges(1);
        global_interrupt_enable_flag <= 1'h1;
        #1;
        chk("dummy", dummy_fetch_addr_reg, 20'h12345);
        chk("refresh", refresh_en, 1'h1);
        chk("halt_n", halt_n_reg, 1'h0);
        chk("addr", addr_out_reg, 20'h12345);
        edges(1);
        #1;
        chk("irq_src", irq_source_reg, 4'h1);
        chk("irq_rsp", irq_response_reg, 1'h1);
        chk("halt_n", halt_n_reg, 1'h1);
        edges(1);
        irq_req <= 9'h000;
        global_interrupt_enable_flag <= 1'h0;
        #1;
        chk("irq_rsp", irq_response_reg, 1'h0);
        $display("halt done");
    endtask
    task t_sleep;
        wr_io(1'h1);
        chk("csio", csio_en, 1'h0);
        send(`PMC_SLEEP_OP0);
        send(`PMC_SLEEP_OP1);
        edges(1);
        opcode_valid <= 1'h0;
        irq_req <= 9'h010;
        want_bus <= 1'h1;
        #1;
        chk("dma", dma_controller_en, 1'h0);
        edges(1);
        #1;
        chk("oe_n", data_oe_n_reg, 1'h1);
        chk("addr", addr_out_reg, `PMC_ADDR_IDLE);
        edges(2);
        irq_req <= 9'h012;
        irq_enable <= 9'h1fc;
        want_bus <= 1'h0;
        #1;
        chk("grant_n", bus_grant_output_n_reg, 1'h0);
        edges(2);
        irq_enable <= 9'h1fe;
        #1;
        chk("halt_n", halt_n_reg, 1'h0);
        edges(1);
        irq_req <= 9'h000;
        #1;
        chk("resume", resume_after_sleep_reg, 1'h1);
        wr_io(1'h0);
        chk("csio", csio_en, 1'h1);
        $display("sleep done");
    endtask
    task t_nmi;
        send(`PMC_SLEEP_OP0);
        global_interrupt_enable_flag <= 1'h1;
        send(`PMC_SLEEP_OP1);
        edges(1);
        opcode_valid <= 1'h0;
        irq_req <= 9'h002;
        edges(1);
        irq_req <= 9'h000;
        #1;
        chk("halt_n", halt_n_reg, 1'h1);
        chk("irq_rsp", irq_response_reg, 1'h1);
        send(`PMC_SLEEP_OP0);
        global_interrupt_enable_flag <= 1'h0;
        send(`PMC_SLEEP_OP1);
        edges(1);
        opcode_valid <= 1'h0;
        edges(1);
        irq_req <= 9'h001;
        edges(1);
        irq_req <= 9'h000;
        #1;
        chk("irq_src", irq_source_reg, 4'h0);
        chk("irq_rsp", irq_response_reg, 1'h1);
        $display("wake done");
    endtask
    task t_rst(input sl);
        wr_io(1'h1);
        if (sl)
            send(`PMC_SLEEP_OP0);
        send(`PMC_HALT_OPCODE);
        edges(1);
        opcode_valid <= 1'h0;
        reset_pin_n <= 1'h0;
        edges(5);
        #1;
        chk("restart", restart_reg, 1'h0);
        edges(1);
        reset_pin_n <= 1'h1;
        edges(1);
        #1;
        chk("restart", restart_reg, 1'h1);
        chk("halt_n", halt_n_reg, 1'h1);
        chk("rst_addr", restart_addr_reg, `PMC_ADDR_ZERO);
        chk("io_stop", io_stop_bit_reg, 1'h0);
        $display("reset pin done");
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        {err_count, total_checks} = 0;
        {arst_n, opcode_valid, io_stop_wr, io_stop_wdata, want_bus} = 5'h00;
        {reset_pin_n, global_interrupt_enable_flag, opcode} = 10'h200;
        {irq_req, irq_enable, pc_next_addr} = {9'h000, 9'h1fe, 20'h00000};
        edges(3);
        arst_n <= 1'h1;
        edges(3);
        t_halt;
        t_sleep;
        t_nmi;
        t_rst(1'h0);
        t_rst(1'h1);
        print_verdict;
    end
endmodule // pmc_power_ctrl_bench
